/* File: rtl/aeop_consts.svh */
// Constants and overview for the area event output pulser
`ifndef AEOP_CONSTS_SVH
`define AEOP_CONSTS_SVH
// Overview of operation
// - An alarm turns the siren channel on only if the zone type allows it.
// - Siren timeout or disarm turns the siren off; login may silence it.
// - Pulse on and off times are 8-bit values, 0 to 255, in 100 ms steps.
// - An active output pulses only when both pulse times are non-zero.
// - A pulsing output repeats on for the on time, then off for the off time.
// - The start of an entry delay turns the entry channel on.
// - Disarm during entry, or the alarm at its expiry, turns it off.
// - The start of an exit delay turns the exit channel on.
// - Arming done, an alarm or a disarm turns the exit channel off.
// - Arming done turns the armed channel on; disarming done turns it off.
// - Disarming done turns the disarmed channel on; arming done turns it off.
// - Any bypassed zone turns the bypass channel on; disarming turns it off.
// - Each channel drives either one output or a group of outputs together.

// Timing
`define AEOP_CLK_HZ     32'h0262_5A00
`define AEOP_MS_PER_S   32'h0000_03E8
`define AEOP_TICK_MS    32'h0000_0064
`define AEOP_TICK_CYC   ((`AEOP_CLK_HZ / `AEOP_MS_PER_S) * `AEOP_TICK_MS)
`define AEOP_T_ZERO     8'h00

// Sizes and channel indices
`define AEOP_NCH        6
`define AEOP_NPGM       16
`define AEOP_CH_BELL    0
`define AEOP_CH_ENTRY   1
`define AEOP_CH_EXIT    2
`define AEOP_CH_ARMED   3
`define AEOP_CH_DISARM  4
`define AEOP_CH_BYPASS  5

// Register map, byte addresses
`define AEOP_A_CTRL     12'h000
`define AEOP_A_STAT     12'h004
`define AEOP_A_PGM      12'h008
`define AEOP_A_CFG0     12'h010
`define AEOP_A_GRP0     12'h030
`define AEOP_STAT_DRV   6

// Reset values
`define AEOP_CTRL_RST   1'b1
`define AEOP_CFG_RST    21'h0_0000
`define AEOP_GRP_RST    16'h0000
`endif

/* File: rtl/aeop_pkg.sv */
// Shared types for the area event output pulser
`include "aeop_consts.svh"
package aeop_pkg;
  typedef struct packed {
    logic alarm;
    logic siren_opt;
    logic siren_tmo;
    logic login;
    logic entry_start;
    logic exit_start;
    logic arm_done;
    logic disarm_done;
    logic bypass_any;
  } aeop_evt_t;

  typedef struct packed {
    logic       grp;
    logic [3:0] idx;
    logic [7:0] off_t;
    logic [7:0] on_t;
  } aeop_cfg_t;

  typedef enum logic [3:0] {
    PLS_IDLE   = 4'b0001,
    PLS_STEADY = 4'b0010,
    PLS_ON     = 4'b0100,
    PLS_OFF    = 4'b1000
  } aeop_pls_st_t;

  typedef struct packed {
    aeop_pls_st_t st;
    logic [7:0]   cnt;
    logic         drv;
  } aeop_pls_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } aeop_tick_t;

  typedef enum logic [2:0] {
    RK_NONE = 3'h0, RK_CTRL = 3'h1, RK_STAT = 3'h2,
    RK_PGM  = 3'h3, RK_CFG  = 3'h4, RK_GRP  = 3'h5
  } aeop_rk_t;

  typedef struct packed {
    aeop_rk_t   kind;
    logic [2:0] ch;
  } aeop_dec_t;

  typedef struct packed {
    logic                                     sil_en;
    aeop_cfg_t [`AEOP_NCH-1:0]                cfg;
    logic [`AEOP_NCH-1:0][`AEOP_NPGM-1:0]     grp;
    logic [`AEOP_NCH-1:0]                     act;
    logic [`AEOP_NPGM-1:0]                    pgm;
  } aeop_top_st_t;
endpackage : aeop_pkg

/* File: rtl/aeop_pulser.sv */
// Per-channel steady or pulsed driver timed by the tick
`timescale 1ns/1ps
`include "aeop_consts.svh"

module aeop_pulser
  import aeop_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  // Control
  input  wire logic       i_act,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_on_t,
  input  wire logic [7:0] i_off_t,
  // Drive
  output logic            o_drive
);
  aeop_pls_t st_q;
  aeop_pls_t st_d;
  logic      pulse_en;

  always_comb begin
    st_d     = st_q;
    pulse_en = (i_on_t != `AEOP_T_ZERO) && (i_off_t != `AEOP_T_ZERO);
    if (!i_act) begin
      st_d.st  = PLS_IDLE;
      st_d.drv = 1'b0;
    end else begin
      unique case (st_q.st)
        PLS_IDLE, PLS_STEADY: begin
          st_d.st  = pulse_en ? PLS_ON : PLS_STEADY;
          st_d.cnt = i_on_t;
          st_d.drv = 1'b1;
        end
        PLS_ON: begin
          if (!pulse_en) begin
            st_d.st  = PLS_STEADY;
            st_d.drv = 1'b1;
          end else if (i_tick && st_q.cnt <= 8'h01) begin
            st_d.st  = PLS_OFF;
            st_d.cnt = i_off_t;
            st_d.drv = 1'b0;
          end else if (i_tick) begin
            st_d.cnt = st_q.cnt - 8'h01;
          end
        end
        PLS_OFF: begin
          if (!pulse_en) begin
            st_d.st  = PLS_STEADY;
            st_d.drv = 1'b1;
          end else if (i_tick && st_q.cnt <= 8'h01) begin
            st_d.st  = PLS_ON;
            st_d.cnt = i_on_t;
            st_d.drv = 1'b1;
          end else if (i_tick) begin
            st_d.cnt = st_q.cnt - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{st: PLS_IDLE, cnt: 8'h00, drv: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_drive = st_q.drv;
endmodule : aeop_pulser

/* File: rtl/aeop_tick_gen.sv */
// 100 ms tick divider for pulse timing
`timescale 1ns/1ps
`include "aeop_consts.svh"

module aeop_tick_gen
  import aeop_pkg::*;
#(
  parameter int TICK_CYCLES = `AEOP_TICK_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  // Tick
  output logic      o_tick
);
  aeop_tick_t st_q;
  aeop_tick_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt >= 32'(TICK_CYCLES - 1)) begin
      st_d.cnt  = 32'h0000_0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{cnt: 32'h0000_0000, tick: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule : aeop_tick_gen

/* File: rtl/aeop_top.sv */
// Area event output driver: channel latches, APB registers, output mux
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "aeop_consts.svh"

module aeop_top
  import aeop_pkg::*;
#(
  parameter int TICK_CYCLES = `AEOP_TICK_CYC
) (
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_b,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Area events
  input  wire aeop_evt_t             i_evt,
  // Programmable outputs
  output logic      [`AEOP_NPGM-1:0] o_pgm
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  aeop_top_st_t           st_q;
  aeop_top_st_t           st_d;
  aeop_dec_t              dec;
  logic                   tick;
  logic                   access;
  logic [`AEOP_NCH-1:0]   drive;
  logic [`AEOP_NCH-1:0]   set;
  logic [`AEOP_NCH-1:0]   clr;
  logic [31:0]            rdata;

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic aeop_dec_t reg_dec(input logic [11:0] a);
    aeop_dec_t d;
    d = '{kind: RK_NONE, ch: 3'h0};
    if (a[1:0] != 2'b00) begin
      d.kind = RK_NONE;
    end else if (a == `AEOP_A_CTRL) begin
      d.kind = RK_CTRL;
    end else if (a == `AEOP_A_STAT) begin
      d.kind = RK_STAT;
    end else if (a == `AEOP_A_PGM) begin
      d.kind = RK_PGM;
    end else if (a >= `AEOP_A_CFG0 &&
                 a < `AEOP_A_CFG0 + 12'(4 * `AEOP_NCH)) begin
      d.kind = RK_CFG;
      d.ch   = 3'((a - `AEOP_A_CFG0) >> 2);
    end else if (a >= `AEOP_A_GRP0 &&
                 a < `AEOP_A_GRP0 + 12'(4 * `AEOP_NCH)) begin
      d.kind = RK_GRP;
      d.ch   = 3'((a - `AEOP_A_GRP0) >> 2);
    end
    return d;
  endfunction : reg_dec

  // Single output or whole group for one channel
  function automatic logic [`AEOP_NPGM-1:0] chan_mask(
    input aeop_cfg_t             c,
    input logic [`AEOP_NPGM-1:0] g
  );
    logic [`AEOP_NPGM-1:0] m;
    m = `AEOP_NPGM'(1) << c.idx;
    if (c.grp) begin
      m = g;
    end
    return m;
  endfunction : chan_mask

  //////////////////////////////////////////////////////////////////////////
  // Tick and per-channel pulsers

  aeop_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .o_tick    (tick)
  );

  for (genvar c = 0; c < `AEOP_NCH; c++) begin : g_ch
    aeop_pulser u_pls (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_act     (st_q.act[c]),
      .i_tick    (tick),
      .i_on_t    (st_q.cfg[c].on_t),
      .i_off_t   (st_q.cfg[c].off_t),
      .o_drive   (drive[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  // Set wins over clear so an event in the clearing cycle is not lost
  always_comb begin
    st_d   = st_q;
    dec    = reg_dec(i_paddr);
    access = i_psel & i_penable;
    set    = '0;
    clr    = '0;
    rdata  = 32'h0000_0000;

    // Siren channel
    set[`AEOP_CH_BELL] = i_evt.alarm & i_evt.siren_opt;
    clr[`AEOP_CH_BELL] = i_evt.siren_tmo | i_evt.disarm_done |
                         (i_evt.login & st_q.sil_en);

    // Entry delay channel
    set[`AEOP_CH_ENTRY] = i_evt.entry_start;
    clr[`AEOP_CH_ENTRY] = i_evt.disarm_done | i_evt.alarm;

    // Exit delay channel
    set[`AEOP_CH_EXIT] = i_evt.exit_start;
    clr[`AEOP_CH_EXIT] = i_evt.arm_done | i_evt.alarm |
                         i_evt.disarm_done;

    // Armed and disarmed state channels
    set[`AEOP_CH_ARMED]  = i_evt.arm_done;
    clr[`AEOP_CH_ARMED]  = i_evt.disarm_done;
    set[`AEOP_CH_DISARM] = i_evt.disarm_done;
    clr[`AEOP_CH_DISARM] = i_evt.arm_done;

    // Bypass channel follows the level, holds until disarm
    set[`AEOP_CH_BYPASS] = i_evt.bypass_any;
    clr[`AEOP_CH_BYPASS] = i_evt.disarm_done;

    st_d.act = set | (st_q.act & ~clr);

    // Output mux, registered so the pins never glitch
    st_d.pgm = '0;
    for (int c = 0; c < `AEOP_NCH; c++) begin
      if (drive[c]) begin
        st_d.pgm = st_d.pgm | chan_mask(st_q.cfg[c], st_q.grp[c]);
      end
    end

    // Register writes; status words ignore writes
    if (access && i_pwrite) begin
      unique case (dec.kind)
        RK_CTRL: st_d.sil_en = i_pwdata[0];
        RK_CFG:  st_d.cfg[dec.ch] = aeop_cfg_t'(i_pwdata[20:0]);
        RK_GRP:  st_d.grp[dec.ch] = i_pwdata[`AEOP_NPGM-1:0];
        RK_NONE, RK_STAT, RK_PGM: begin
        end
      endcase
    end

    // Register reads
    unique case (dec.kind)
      RK_CTRL: rdata = {31'h0000_0000, st_q.sil_en};
      RK_STAT: rdata = {20'h0_0000, drive, st_q.act};
      RK_PGM:  rdata = {16'h0000, st_q.pgm};
      RK_CFG:  rdata = {11'h000, st_q.cfg[dec.ch]};
      RK_GRP:  rdata = {16'h0000, st_q.grp[dec.ch]};
      RK_NONE: rdata = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q.sil_en <= `AEOP_CTRL_RST;
      st_q.cfg    <= {`AEOP_NCH{`AEOP_CFG_RST}};
      st_q.grp    <= {`AEOP_NCH{`AEOP_GRP_RST}};
      st_q.act    <= '0;
      st_q.pgm    <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states: every access completes in its first access cycle
  assign o_pready  = access;
  assign o_pslverr = access & (dec.kind == RK_NONE);
  assign o_prdata  = access ? rdata : 32'h0000_0000;
  assign o_pgm     = st_q.pgm;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  property p_bell_on;
    i_evt.alarm && i_evt.siren_opt |=> st_q.act[`AEOP_CH_BELL];
  endproperty
  a_bell_on: assert property (p_bell_on)
    else $error("siren channel missed a permitted alarm");

  property p_bell_gate;
    !(i_evt.alarm && i_evt.siren_opt) && !st_q.act[`AEOP_CH_BELL]
      |=> !st_q.act[`AEOP_CH_BELL];
  endproperty
  a_bell_gate: assert property (p_bell_gate)
    else $error("siren channel set without a permitted alarm");

  property p_bell_off;
    !(i_evt.alarm && i_evt.siren_opt) &&
      (i_evt.siren_tmo || i_evt.disarm_done)
      |=> !st_q.act[`AEOP_CH_BELL];
  endproperty
  a_bell_off: assert property (p_bell_off)
    else $error("siren channel not released by timeout or disarm");

  property p_bell_login;
    i_evt.login && st_q.sil_en && !(i_evt.alarm && i_evt.siren_opt)
      |=> !st_q.act[`AEOP_CH_BELL];
  endproperty
  a_bell_login: assert property (p_bell_login)
    else $error("login did not silence the siren channel");

  // Login only silences when software allows it
  property p_bell_keep;
    i_evt.login && !st_q.sil_en && st_q.act[`AEOP_CH_BELL] &&
      !i_evt.siren_tmo && !i_evt.disarm_done
      |=> st_q.act[`AEOP_CH_BELL];
  endproperty
  a_bell_keep: assert property (p_bell_keep)
    else $error("login silenced the siren channel while disabled");

  property p_entry_on;
    i_evt.entry_start |=> st_q.act[`AEOP_CH_ENTRY];
  endproperty
  a_entry_on: assert property (p_entry_on)
    else $error("entry channel not set at entry start");

  property p_entry_off;
    !i_evt.entry_start && (i_evt.disarm_done || i_evt.alarm)
      |=> !st_q.act[`AEOP_CH_ENTRY];
  endproperty
  a_entry_off: assert property (p_entry_off)
    else $error("entry channel not cleared");

  property p_exit_on;
    i_evt.exit_start |=> st_q.act[`AEOP_CH_EXIT];
  endproperty
  a_exit_on: assert property (p_exit_on)
    else $error("exit channel not set at exit start");

  property p_exit_off;
    !i_evt.exit_start &&
      (i_evt.arm_done || i_evt.alarm || i_evt.disarm_done)
      |=> !st_q.act[`AEOP_CH_EXIT];
  endproperty
  a_exit_off: assert property (p_exit_off)
    else $error("exit channel not cleared");

  property p_armed;
    i_evt.arm_done && !i_evt.disarm_done
      |=> st_q.act[`AEOP_CH_ARMED] && !st_q.act[`AEOP_CH_DISARM];
  endproperty
  a_armed: assert property (p_armed)
    else $error("armed and disarmed channels wrong after arming");

  property p_disarmed;
    i_evt.disarm_done && !i_evt.arm_done
      |=> st_q.act[`AEOP_CH_DISARM] && !st_q.act[`AEOP_CH_ARMED];
  endproperty
  a_disarmed: assert property (p_disarmed)
    else $error("armed and disarmed channels wrong after disarming");

  property p_bypass;
    i_evt.bypass_any |=> st_q.act[`AEOP_CH_BYPASS];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass channel off while a zone is bypassed");

  property p_group;
    drive[`AEOP_CH_ARMED] && st_q.cfg[`AEOP_CH_ARMED].grp
      |=> (o_pgm & $past(st_q.grp[`AEOP_CH_ARMED])) ==
          $past(st_q.grp[`AEOP_CH_ARMED]);
  endproperty
  a_group: assert property (p_group)
    else $error("group outputs not all driven");

  property p_steady;
    (st_q.act[`AEOP_CH_ARMED] &&
     st_q.cfg[`AEOP_CH_ARMED].on_t == `AEOP_T_ZERO) [*3]
      |-> drive[`AEOP_CH_ARMED];
  endproperty
  a_steady: assert property (p_steady)
    else $error("steady output not held on");

  property p_phase_tick;
    $fell(drive[`AEOP_CH_ARMED]) && st_q.act[`AEOP_CH_ARMED] &&
      $past(st_q.act[`AEOP_CH_ARMED]) |-> $past(tick);
  endproperty
  a_phase_tick: assert property (p_phase_tick)
    else $error("pulse phase changed without a tick");

  property p_tick_gap;
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick wider than one cycle");

  // A pulser may only drive while its channel was active one edge before
  property p_drive_gate;
    (drive & ~$past(st_q.act)) == '0;
  endproperty
  a_drive_gate: assert property (p_drive_gate)
    else $error("channel driven while inactive");

  property p_single_out;
    drive[`AEOP_CH_EXIT] && !st_q.cfg[`AEOP_CH_EXIT].grp
      |=> o_pgm[$past(st_q.cfg[`AEOP_CH_EXIT].idx)];
  endproperty
  a_single_out: assert property (p_single_out)
    else $error("single output not driven for its channel");

  property p_pgm_idle;
    drive == '0 |=> o_pgm == '0;
  endproperty
  a_pgm_idle: assert property (p_pgm_idle)
    else $error("output driven with no channel driving");

  property p_cfg_write;
    access && i_pwrite && dec.kind == RK_CFG
      |=> st_q.cfg[$past(dec.ch)] == $past(i_pwdata[20:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("pulse settings not stored");

  c_bell_alarm: cover property (
    i_evt.alarm && i_evt.siren_opt ##2 drive[`AEOP_CH_BELL]);
  c_pulse_off: cover property (
    $fell(drive[`AEOP_CH_EXIT]) && st_q.act[`AEOP_CH_EXIT]);
  c_group_out: cover property (
    drive[`AEOP_CH_BYPASS] && st_q.cfg[`AEOP_CH_BYPASS].grp);

endmodule : aeop_top

/* File: test/aeop_relay_bank.sv */
// Relay and indicator bank on the far side of the programmable outputs
`timescale 1ns/1ps

module aeop_relay_bank (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Drive from the outputs
  input  wire logic [15:0] i_pgm,
  // Contact state
  output logic      [15:0] o_coil
);
  // Coils lag their drive by one clock, so run lengths are unchanged
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_coil <= 16'h0000;
    end else begin
      o_coil <= i_pgm;
    end
  end
endmodule : aeop_relay_bank

/* File: test/area_event_output_pulser_bench.sv */
// Self-checking bench for the area event output pulser
`timescale 1ns/1ps
`include "aeop_consts.svh"

module area_event_output_pulser_bench
  import aeop_pkg::*;
;
  localparam int TK = 10;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  aeop_evt_t   evt     = 9'h000;
  logic [15:0] pgm;
  logic [15:0] coil;
  logic [32:0] exp_q[$];
  logic [3:0]  base;
  logic [15:0] gmask;
  logic [31:0] junk;
  int          pb;
  int          n_errors    = 0;
  int          checks_done = 0;
  logic [8:0]  ev_t [20] = '{9'h100, 9'h002, 9'h008, 9'h004, 9'h010,
    9'h180, 9'h040, 9'h180, 9'h020, 9'h008, 9'h100, 9'h010, 9'h001,
    9'h002, 9'h008, 9'h002, 9'h180, 9'h020, 9'h002, 9'h1C0};
  logic [5:0]  act_t [20] = '{6'h00, 6'h10, 6'h14, 6'h08, 6'h0A, 6'h09,
    6'h08, 6'h09, 6'h08, 6'h0C, 6'h08, 6'h0A, 6'h2A, 6'h10, 6'h14, 6'h10,
    6'h11, 6'h11, 6'h10, 6'h11};
  logic [7:0]  on_t [5]  = '{8'h02, 8'h01, 8'hFF, 8'h00, 8'h04};
  logic [7:0]  off_t [5] = '{8'h01, 8'h03, 8'h01, 8'h05, 8'h00};

  always #12.5 clk_sys = ~clk_sys;

  aeop_top #(.TICK_CYCLES(TK)) i_dut (
    .i_clk_sys (clk_sys),
    .i_rst_b   (rst_b),
    .i_psel    (psel),
    .i_penable (penable),
    .i_pwrite  (pwrite),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .i_evt     (evt),
    .o_pgm     (pgm)
  );

  aeop_relay_bank i_relay (
    .i_clk_sys (clk_sys),
    .i_rst_b   (rst_b),
    .i_pgm     (pgm),
    .o_coil    (coil)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 50) begin
        n_errors++;
        results();
      end
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps the next setup off this edge
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic cfg(input int ch, input logic [20:0] v);
    apb(1'b1, `AEOP_A_CFG0 + 12'(4 * ch), {11'h000, v});
    rd(`AEOP_A_CFG0 + 12'(4 * ch), {12'h000, v});
  endtask : cfg

  task automatic ev(input aeop_evt_t v);
    evt <= v;
    @(posedge clk_sys);
    evt <= 9'h000;
    repeat (4) @(posedge clk_sys);
  endtask : ev

  task automatic run(input logic lvl, output int n);
    n = 0;
    // Coil is read as it stood before each edge, so lengths stay exact
    while (coil[pb] === lvl) begin
      @(posedge clk_sys);
      n++;
      if (n > 3000) begin
        n_errors++;
        results();
      end
    end
  endtask : run

  function automatic logic [15:0] map(input logic [5:0] act);
    logic [15:0] m;
    m = act[5] ? gmask : 16'h0000;
    for (int c = 0; c < 5; c++) begin
      if (act[c]) m[base + 4'(c)] = 1'b1;
    end
    return m;
  endfunction : map

  ////////////////////////////////////////////////////////////////////////
  // Read results are judged here against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        n_errors++;
      end else begin
        cmp({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  initial begin
    int n;
    int hi;
    int lo;
    junk = $urandom(60);
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(`AEOP_A_CTRL, {32'h0000_0000, 1'b1});
    apb(1'b1, `AEOP_A_STAT, 32'hFFFF_FFFF);
    rd(`AEOP_A_STAT, 33'h0_0000_0000);
    rd(`AEOP_A_PGM, 33'h0_0000_0000);
    rd(`AEOP_A_GRP0, 33'h0_0000_0000);
    rd(12'h00C, {1'b1, 32'h0000_0000});
    rd(12'h002, {1'b1, 32'h0000_0000});
    base = 4'($urandom % 4);
    gmask = {8'($urandom % 255 + 1), 8'h00};
    for (int c = 0; c < 5; c++) cfg(c, {1'b0, base + 4'(c), 16'h0000});
    cfg(5, {1'b1, 4'h0, 16'h0000});
    apb(1'b1, `AEOP_A_GRP0 + 12'h014, {16'h0000, gmask});
    rd(`AEOP_A_GRP0 + 12'h014, {17'h0_0000, gmask});
    $display("test registers done");
    for (int i = 0; i < 20; i++) begin
      // Last entries run with login silencing turned off
      if (i == 16) apb(1'b1, `AEOP_A_CTRL, 32'h0000_0000);
      ev(ev_t[i]);
      rd(`AEOP_A_STAT, {21'h00_0000, act_t[i], act_t[i]});
      rd(`AEOP_A_PGM, {17'h0_0000, map(act_t[i])});
    end
    $display("test events done");
    pb = base + 3;
    for (int k = 0; k < 5; k++) begin
      ev(9'h002);
      cfg(3, {1'b0, base + 4'h3, off_t[k], on_t[k]});
      ev(9'h004);
      if (on_t[k] != 8'h00 && off_t[k] != 8'h00) begin
        run(1'b1, n);
        run(1'b0, n);
        run(1'b1, hi);
        run(1'b0, lo);
        cmp(33'(hi), 33'(on_t[k] * TK));
        cmp(33'(lo), 33'(off_t[k] * TK));
      end else begin
        n = 0;
        repeat (30 * TK) begin
          @(posedge clk_sys);
          if (coil[pb] !== 1'b1) n++;
        end
        cmp(33'(n), 33'h0_0000_0000);
      end
    end
    $display("test pulse done");
    results();
  end
endmodule : area_event_output_pulser_bench
